//--- hdl/acc_cfg.sv
// Conversion setup word, conversion control and result FIFO
module acc_cfg
	import acc_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RSTN,
	input wire logic I_CONV_PIN,
	input wire logic I_WR_STB,
	input wire logic [11:0] I_WDATA,
	input wire logic I_RD_STB,
	input wire logic [11:0] I_SAMPLE,
	input wire logic [4:0] I_TRIG_LVL,
	output logic O_EXT_REF_SEL,
	output logic O_SINGLE_MODE,
	output logic O_POWER_DOWN,
	output logic O_HOLD,
	output logic [2:0] O_CHAN_CODE,
	output logic [1:0] O_TEST_SEL,
	output logic [11:0] O_RDATA,
	output logic O_RESULTS_READY_N
);

	acc_st_s st;
	acc_st_s n;
	logic fall;
	logic conv_fire;
	logic rd_fire;
	logic wr_ok;
	logic cfg_wr;
	logic [2:0] len;
	logic last_item;
	logic [4:0] trig_eff;

	function automatic logic [2:0] seq_len(input logic [9:0] c);
		logic [4:0] k;
		k = c[7:3];
		case (k)
			5'h11: seq_len = 3'h2;
			5'h12: seq_len = 3'h3;
			5'h13: seq_len = 3'h4;
			5'h15: seq_len = 3'h2;
			5'h16: seq_len = 3'h3;
			5'h19: seq_len = 3'h2;
			default: seq_len = 3'h1;
		endcase
	endfunction : seq_len

	// Reserved combinations fall back to the first single-ended input
	function automatic acc_chan_t seq_item(input logic [9:0] c, input logic [1:0] i);
		logic [4:0] k;
		k = c[7:3];
		seq_item = ACC_AINP;
		case (k)
			5'h00: seq_item = ACC_AINP;
			5'h01: seq_item = ACC_AINM;
			5'h02: seq_item = ACC_BINP;
			5'h03: seq_item = ACC_BINM;
			5'h04: seq_item = ACC_DIFA;
			5'h05: seq_item = ACC_DIFB;
			5'h11, 5'h12, 5'h13: seq_item = acc_chan_t'({1'b0, i});
			5'h15: seq_item = (i == 2'h0) ? ACC_AINP : ACC_DIFB;
			5'h16: seq_item = (i == 2'h2) ? ACC_DIFB : acc_chan_t'({1'b0, i});
			5'h19: seq_item = (i == 2'h0) ? ACC_DIFA : ACC_DIFB;
			default: seq_item = ACC_AINP;
		endcase
	endfunction : seq_item

	function automatic acc_test_e test_dec(input logic [1:0] t);
		case (t)
			2'h1: test_dec = ACC_T_REFP;
			2'h2: test_dec = ACC_T_MID;
			2'h3: test_dec = ACC_T_REFM;
			default: test_dec = ACC_T_NORMAL;
		endcase
	endfunction : test_dec

	// Only the second and third stages are compared, the first stage feeds the second alone
	assign fall = st.s3_r & ~st.s2_r;
	assign cfg_wr = I_WR_STB && (I_WDATA[11:10] == `ACC_ADDR_SETUP);
	assign len = seq_len(st.cfg_r);
	assign last_item = ({1'b0, st.idx_r} + 3'h1) >= len;
	assign trig_eff = (I_TRIG_LVL == 5'h00) ? 5'h01 : I_TRIG_LVL;

	// Power down stops conversions but leaves register and FIFO access alive
	always_comb begin
		conv_fire = 1'b0;
		if (!st.cfg_r[`ACC_B_PD]) begin
			if (!st.cfg_r[`ACC_B_MODE]) begin
				conv_fire = fall;
			end else begin
				conv_fire = (st.fsm_r == ACC_RUN) && (st.step_r == `ACC_STEP_CYC - 4'h1);
			end
		end
	end

	assign rd_fire = I_RD_STB && (st.cnt_r != 5'h00);
	// A full buffer drops the new result unless a read frees a slot
	assign wr_ok = conv_fire && ((st.cnt_r != `ACC_FIFO_DEPTH) || rd_fire);

	always_comb begin
		n = st;
		n.s1_r = I_CONV_PIN;
		n.s2_r = st.s1_r;
		n.s3_r = st.s2_r;
		n.ready_n_r = 1'b1;
		case (st.fsm_r)
			ACC_IDLE: begin
				if (st.cfg_r[`ACC_B_MODE] && !st.cfg_r[`ACC_B_PD] && fall) begin
					n.fsm_r = ACC_HOLD;
					n.hold_r = 1'b1;
					n.idx_r = 2'h0;
				end
			end
			ACC_HOLD: begin
				n.fsm_r = ACC_RUN;
				n.step_r = 4'h0;
			end
			ACC_RUN: begin
				if (st.cfg_r[`ACC_B_PD] || !st.cfg_r[`ACC_B_MODE]) begin
					n.fsm_r = ACC_IDLE;
					n.hold_r = 1'b0;
					n.idx_r = 2'h0;
				end else if (st.step_r == `ACC_STEP_CYC - 4'h1) begin
					n.step_r = 4'h0;
					if (last_item) begin
						n.fsm_r = ACC_IDLE;
						n.hold_r = 1'b0;
						n.idx_r = 2'h0;
					end else begin
						n.idx_r = st.idx_r + 2'h1;
					end
				end else begin
					n.step_r = st.step_r + 4'h1;
				end
			end
			default: begin
				n.fsm_r = ACC_IDLE;
				n.hold_r = 1'b0;
			end
		endcase
		if (conv_fire && !st.cfg_r[`ACC_B_MODE]) begin
			n.idx_r = last_item ? 2'h0 : st.idx_r + 2'h1;
		end
		if (wr_ok) begin
			n.mem_r[st.wp_r] = I_SAMPLE;
			n.wp_r = st.wp_r + 4'h1;
			if ((st.wcnt_r + 5'h01) >= trig_eff) begin
				n.ready_n_r = 1'b0;
				n.wcnt_r = 5'h00;
			end else begin
				n.wcnt_r = st.wcnt_r + 5'h01;
			end
		end
		if (rd_fire) begin
			n.rdata_r = st.mem_r[st.rp_r];
			n.rp_r = st.rp_r + 4'h1;
		end
		n.cnt_r = st.cnt_r + {4'h0, wr_ok} - {4'h0, rd_fire};
		// A new setup word restarts the scan order at its first input
		if (cfg_wr) begin
			n.cfg_r = I_WDATA[9:0];
			n.idx_r = 2'h0;
		end
		n.chan_r = seq_item(n.cfg_r, n.idx_r);
		n.test_r = test_dec(n.cfg_r[9:8]);
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			st <= '0;
			st.cfg_r <= `ACC_SETUP_RST;
			st.fsm_r <= ACC_IDLE;
			st.ready_n_r <= 1'b1;
			st.test_r <= ACC_T_NORMAL;
			st.chan_r <= ACC_DIFA;
		end else begin
			st <= n;
		end
	end

	assign O_EXT_REF_SEL = st.cfg_r[`ACC_B_VREF];
	assign O_SINGLE_MODE = st.cfg_r[`ACC_B_MODE];
	assign O_POWER_DOWN = st.cfg_r[`ACC_B_PD];
	assign O_HOLD = st.hold_r;
	assign O_CHAN_CODE = st.chan_r;
	assign O_TEST_SEL = st.test_r;
	assign O_RDATA = st.rdata_r;
	assign O_RESULTS_READY_N = st.ready_n_r;

	default clocking acc_cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RSTN);

	sequence start_seen;
		st.cfg_r[`ACC_B_MODE] && !st.cfg_r[`ACC_B_PD] && fall && (st.fsm_r == ACC_IDLE);
	endsequence

	sequence hold_span;
		O_HOLD [*2];
	endsequence

	sequence hold_done;
		##[1:40] !O_HOLD;
	endsequence

	ext_ref_follow_a: assert property (
		cfg_wr |=> O_EXT_REF_SEL == $past(I_WDATA[0]))
		else $error("reference select does not follow write");

	cont_store_a: assert property (
		(!O_SINGLE_MODE && !O_POWER_DOWN && fall && st.cnt_r < 5'h0F)
		|=> st.cnt_r == $past(st.cnt_r) + 5'h01 - {4'h0, $past(rd_fire)})
		else $error("continuous edge did not store a result");

	start_hold_a: assert property (
		start_seen |=> hold_span)
		else $error("start edge did not place inputs in hold");

	seq_finish_a: assert property (
		$rose(O_HOLD) |-> hold_done)
		else $error("conversion sequence did not finish");

	ready_cause_a: assert property (
		$fell(O_RESULTS_READY_N) |-> $past(wr_ok))
		else $error("data available without a stored result");

	ready_pulse_a: assert property (
		!O_RESULTS_READY_N |=> O_RESULTS_READY_N)
		else $error("data available pulse longer than one cycle");

	pd_no_conv_a: assert property (
		(O_POWER_DOWN && !rd_fire) |=> st.cnt_r == $past(st.cnt_r))
		else $error("conversion while powered down");

	pd_read_a: assert property (
		(O_POWER_DOWN && rd_fire && !conv_fire)
		|=> st.cnt_r == $past(st.cnt_r) - 5'h01)
		else $error("FIFO read blocked in power down");

	chan_range_a: assert property (
		O_CHAN_CODE <= ACC_DIFB)
		else $error("channel code out of range");

	test_decode_a: assert property (
		cfg_wr |=> O_TEST_SEL == $past(I_WDATA[9:8]))
		else $error("test voltage decode wrong");

	addr_guard_a: assert property (
		(I_WR_STB && I_WDATA[11:10] != 2'h0) |=> $stable(st.cfg_r))
		else $error("write to other address changed setup word");

	mode_follow_a: assert property (
		cfg_wr |=> O_SINGLE_MODE == $past(I_WDATA[1]))
		else $error("mode bit does not follow write");

	pd_follow_a: assert property (
		cfg_wr |=> O_POWER_DOWN == $past(I_WDATA[2]))
		else $error("power down bit does not follow write");

	// Only an accepted write may move the setup outputs
	cfg_stable_a: assert property (
		!cfg_wr |=> $stable({O_EXT_REF_SEL, O_SINGLE_MODE, O_POWER_DOWN, O_TEST_SEL}))
		else $error("setup output moved without a write");

	chan_pick_a: assert property (
		(cfg_wr && I_WDATA[7:6] == 2'h0 && I_WDATA[5:3] <= 3'h5)
		|=> O_CHAN_CODE == $past(I_WDATA[5:3]))
		else $error("fixed input selection wrong");

	fixed_chan_a: assert property (
		(conv_fire && !st.cfg_r[`ACC_B_SCAN] && !cfg_wr) |=> $stable(O_CHAN_CODE))
		else $error("fixed input moved after a store");

	scan_step_a: assert property (
		(conv_fire && st.cfg_r[`ACC_B_SCAN] && len != 3'h1 && !cfg_wr)
		|=> O_CHAN_CODE != $past(O_CHAN_CODE))
		else $error("scan did not step to the next input");

	cont_no_hold_a: assert property (
		(!O_SINGLE_MODE && !O_HOLD) |=> !O_HOLD)
		else $error("hold raised in continuous mode");

	idle_no_store_a: assert property (
		(O_SINGLE_MODE && !O_HOLD) |=> st.cnt_r <= $past(st.cnt_r))
		else $error("single mode stored without a sequence");

	// A sequence that ends on its own ends with a conversion; aborts are excluded
	seq_end_a: assert property (
		($fell(O_HOLD) && $past(O_SINGLE_MODE) && !$past(O_POWER_DOWN)) |-> $past(conv_fire))
		else $error("sequence ended without converting its last input");

	empty_read_a: assert property (
		(I_RD_STB && st.cnt_r == 5'h00) |=> $stable(O_RDATA))
		else $error("read of empty buffer changed read data");

	fifo_bound_a: assert property (
		st.cnt_r <= `ACC_FIFO_DEPTH)
		else $error("result count above buffer depth");

	trig_one_a: assert property (
		(wr_ok && I_TRIG_LVL <= 5'h01) |=> !O_RESULTS_READY_N)
		else $error("no data available after store at level one");

endmodule : acc_cfg

//--- hdl/acc_map.svh
// Offsets, field positions, reset values and timing counts of the conversion setup block
// Summary of operation
// - Bit 0 resets to 0; 0 picks internal reference, 1 external reference.
// - Setting bit 0 switches the converter over to the external reference.
// - Bit 1 resets to 0; 0 selects continuous conversion on external clock.
// - Continuous mode stores one result per falling edge of the conversion clock.
// - Bit 1 set selects single conversion, one sequence per start pulse.
// - In single mode the shared pin is a start input pulsed by the host.
// - Falling start edge puts all selected sample-and-hold stages into hold together.
// - After hold, every currently selected channel is converted in sequence.
// - Data-available asserts once stored results reach the trigger level.
// - Bit 2 resets to 0 (active); 1 powers down, bus access still works.
// - FIFO contents stay readable while powered down.
// - Bits 3 and 4 reset to 0,0 and pick the input channel.
// - Bits 5 and 6 reset to 1,0 and give the differential channel count.
// - Bit 7 resets to 0; set, conversions step through selected inputs in order.
// - Bits 8 and 9 reset to 0,0 and pick a test voltage instead of inputs.
// - Test field: 00 normal, 01 positive ref, 10 midpoint, 11 negative ref.
// - Data-available is a low pulse; host then reads trigger-level results.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
`define ACC_ADDR_SETUP 2'h0
`define ACC_SETUP_RST 10'h020
`define ACC_B_VREF 0
`define ACC_B_MODE 1
`define ACC_B_PD 2
`define ACC_B_SCAN 7
`define ACC_F_SEL_LO 3
`define ACC_F_TEST_LO 8
`define ACC_STEP_CYC 4'h8
`define ACC_FIFO_DEPTH 5'h10
`endif

//--- hdl/acc_pkg.sv
// Types shared by the conversion setup block
`include "acc_map.svh"
package acc_pkg;
	typedef enum logic [2:0] {
		ACC_IDLE = 3'b001,
		ACC_HOLD = 3'b010,
		ACC_RUN = 3'b100
	} acc_state_e;
	typedef enum logic [1:0] {
		ACC_T_NORMAL = 2'h0,
		ACC_T_REFP = 2'h1,
		ACC_T_MID = 2'h2,
		ACC_T_REFM = 2'h3
	} acc_test_e;
	typedef logic [2:0] acc_chan_t;
	localparam acc_chan_t ACC_AINP = 3'h0;
	localparam acc_chan_t ACC_AINM = 3'h1;
	localparam acc_chan_t ACC_BINP = 3'h2;
	localparam acc_chan_t ACC_BINM = 3'h3;
	localparam acc_chan_t ACC_DIFA = 3'h4;
	localparam acc_chan_t ACC_DIFB = 3'h5;
	typedef struct packed {
		logic [9:0] cfg_r;
		logic s1_r;
		logic s2_r;
		logic s3_r;
		acc_state_e fsm_r;
		logic [3:0] step_r;
		logic [1:0] idx_r;
		logic [15:0][11:0] mem_r;
		logic [3:0] wp_r;
		logic [3:0] rp_r;
		logic [4:0] cnt_r;
		logic [4:0] wcnt_r;
		logic hold_r;
		acc_chan_t chan_r;
		acc_test_e test_r;
		logic [11:0] rdata_r;
		logic ready_n_r;
	} acc_st_s;
endpackage : acc_pkg

//--- verification/acc_cfg_tb_top.sv
// Self-checking bench for the conversion setup block
module acc_cfg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, wr, rd, go, pin, ext, single, pd, hold, rdy_n;
	logic [11:0] wdata, sample, rdata;
	logic [4:0] trig;
	logic [3:0] n_edges;
	logic [2:0] chan;
	logic [1:0] tsel;
	int n_fail, cmp_count, n_pulse, p0;
	logic [9:0] row_w [6] = '{10'h001, 10'h10A, 10'h214, 10'h318, 10'h028, 10'h020};
	logic [7:0] row_e [6] = '{8'h80, 8'h45, 8'h2A, 8'h0F, 8'h14, 8'h10};
	wire logic [7:0] cfg = {ext, single, pd, chan, tsel};
	acc_cfg acc_cfg_inst (
		.I_REF_CLK(clk), .I_RSTN(rstn), .I_CONV_PIN(pin), .I_WR_STB(wr), .I_WDATA(wdata),
		.I_RD_STB(rd), .I_SAMPLE(sample), .I_TRIG_LVL(trig), .O_EXT_REF_SEL(ext),
		.O_SINGLE_MODE(single), .O_POWER_DOWN(pd), .O_HOLD(hold), .O_CHAN_CODE(chan),
		.O_TEST_SEL(tsel), .O_RDATA(rdata), .O_RESULTS_READY_N(rdy_n)
	);
	acc_host_model acc_host_model_inst (
		.clk(clk), .rstn(rstn), .go(go), .n_edges(n_edges), .pin(pin), .sample(sample)
	);
	always #5 clk = ~clk;
	// Pulses are one cycle wide, so low cycles equal pulses
	always @(posedge clk) if (rdy_n === 1'b0) n_pulse <= n_pulse + 1;
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	task automatic wr_word(input logic [11:0] d);
		@(posedge clk);
		wr <= 1'b1;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
		#1;
	endtask : wr_word
	task automatic rd_word(input logic [11:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		#1;
		check(rdata, exp);
	endtask : rd_word
	task automatic fire(input logic [3:0] n);
		@(posedge clk);
		go <= 1'b1;
		n_edges <= n;
		@(posedge clk);
		go <= 1'b0;
	endtask : fire
	task automatic edges(input logic [3:0] n);
		fire(n);
		repeat (8 * n + 10) @(posedge clk);
	endtask : edges
	task automatic wait_hold(input logic lvl);
		int i;
		for (i = 0; i < 60 && hold !== lvl; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 60) begin
			$display("MISMATCH t=%0t hold wait ran out", $time);
			n_fail++;
			wrap_up();
		end
	endtask : wait_hold
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		go = 1'b0;
		wdata = 12'h000;
		n_edges = 4'h0;
		trig = 5'h02;
		repeat (8) @(posedge clk);
		check({4'h0, cfg}, 12'h010);
		check({11'h0, rdy_n}, 12'h001);
		rstn <= 1'b1;
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			wr_word({2'b00, row_w[k]});
			check({4'h0, cfg}, {4'h0, row_e[k]});
		end
		wr_word({2'b01, 10'h3FF});
		check({4'h0, cfg}, 12'h010);
		$display("test table done");
		wr_word(12'h000);
		p0 = n_pulse;
		edges(4'h4);
		check(12'(n_pulse - p0), 12'h002);
		wr_word(12'h004);
		check({4'h0, cfg}, 12'h020);
		for (int k = 0; k < 4; k++) rd_word(12'h5A0 + 12'(k));
		// An edge in power down must store nothing, so the empty read leaves data alone
		edges(4'h1);
		rd_word(12'h5A3);
		$display("test continuous done");
		wr_word(12'h08A);
		p0 = n_pulse;
		fire(4'h1);
		wait_hold(1'b1);
		check({11'h0, hold}, 12'h001);
		check({9'h0, chan}, 12'h000);
		repeat (12) @(posedge clk);
		#1;
		check({9'h0, chan}, 12'h001);
		wait_hold(1'b0);
		repeat (3) @(posedge clk);
		check(12'(n_pulse - p0), 12'h001);
		check({9'h0, chan}, 12'h000);
		rd_word(12'h5A6);
		rd_word(12'h5A6);
		$display("test single done");
		@(posedge clk);
		trig <= 5'h00;
		wr_word(12'h0B0);
		p0 = n_pulse;
		check({9'h0, chan}, 12'h000);
		edges(4'h1);
		check({9'h0, chan}, 12'h001);
		edges(4'h1);
		check({9'h0, chan}, 12'h005);
		edges(4'h1);
		check({9'h0, chan}, 12'h000);
		check(12'(n_pulse - p0), 12'h003);
		for (int k = 0; k < 3; k++) rd_word(12'h5A6 + 12'(k));
		$display("test scan done");
		wr_word(12'h000);
		edges(4'hF);
		edges(4'h2);
		for (int k = 0; k < 16; k++) rd_word(12'h5A9 + 12'(k));
		rd_word(12'h5B8);
		$display("test full done");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check({4'h0, cfg}, 12'h010);
		check({10'h0, hold, rdy_n}, 12'h001);
		check(rdata, 12'h000);
		@(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check({4'h0, cfg}, 12'h010);
		wr_word(12'h001);
		check({4'h0, cfg}, 12'h080);
		$display("test reset again done");
		wrap_up();
	end
endmodule : acc_cfg_tb_top

//--- verification/acc_host_model.sv
// Host side model: drives the shared conversion pin and the converter sample
module acc_host_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic go,
	input wire logic [3:0] n_edges,
	output logic pin,
	output logic [11:0] sample
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] left;
	logic [2:0] ph;
	// Pin idles high and stays low four cycles, four times the one-cycle minimum the block needs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin <= 1'b1;
			left <= 4'h0;
			ph <= 3'h0;
			sample <= 12'h5A0;
		end else if (go) begin
			left <= n_edges;
		end else if (left != 4'h0) begin
			ph <= ph + 3'h1;
			if (ph == 3'h3) begin
				pin <= 1'b0;
			end
			// Sample moves only at the rising edge, so each store sees one stable value
			if (ph == 3'h7) begin
				pin <= 1'b1;
				left <= left - 4'h1;
				sample <= sample + 12'h001;
			end
		end
	end
endmodule : acc_host_model
